/* inc/rbcp_params.svh */
// Constants for the reset, low-voltage and code protection block.
`ifndef RBCP_PARAMS_SVH
`define RBCP_PARAMS_SVH
`define RBCP_ADDR_W        4
`define RBCP_REG_STATUS    4'h0
`define RBCP_REG_CTRL      4'h1
`define RBCP_REG_PROT      4'h2
`define RBCP_REG_SOURCE    4'h3
`define RBCP_PAT_LEVEL1    32'h12345678
`define RBCP_PAT_LEVEL2    32'h87654321
`define RBCP_PAT_LEVEL3    32'h43218765
`define RBCP_WAKE_NS       1000
`define RBCP_CLK_MHZ       200
`define RBCP_WAKE_CYC      ((`RBCP_WAKE_NS * `RBCP_CLK_MHZ + 999) / 1000)
`define RBCP_HYST_CYC      16
`define RBCP_BOOT_ADDR     32'h00000000
`define RBCP_SRC_PIN       0
`define RBCP_SRC_WDT       1
`define RBCP_SRC_POR       2
`define RBCP_SRC_LVD       3
`endif

/* inc/rbcp_pkg.sv */
// Types shared by the reset, low-voltage and code protection block.
package rbcp_pkg;
	typedef enum logic [1:0] {
		RBCP_PROT_NONE,
		RBCP_PROT_ONE,
		RBCP_PROT_TWO,
		RBCP_PROT_THREE
	} rbcp_level_e;
	typedef enum logic [1:0] {
		RBCP_ST_HOLD,
		RBCP_ST_WAIT,
		RBCP_ST_RUN
	} rbcp_state_e;
endpackage

/* rtl/rbcp_filter.sv */
// Hysteresis filter: output changes only after the input holds a new level for a count.
`include "rbcp_params.svh"
module rbcp_filter #(
	parameter int COUNT = `RBCP_HYST_CYC
) (
	input  wire logic core_clk_in,
	input  wire logic nrst_in,
	input  wire logic raw_in,
	output logic      level_out
);
	logic [7:0] cnt;

	// A change must persist for COUNT cycles, so a supply hovering at the threshold cannot toggle.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt       <= 8'h00;
			level_out <= 1'b0;
		end else if (raw_in == level_out) begin
			cnt <= 8'h00;
		end else if (cnt == 8'(COUNT - 1)) begin
			cnt       <= 8'h00;
			level_out <= raw_in;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

/* rtl/rbcp_top.sv */
// Reset combiner, wake-up timer, two-stage low-voltage detector and code read protection.
`include "rbcp_params.svh"
module rbcp_top
	import rbcp_pkg::*;
#(
	parameter int WAKE_CYC = `RBCP_WAKE_CYC
) (
	input  wire logic        core_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        reset_pin_n_in,
	input  wire logic        watchdog_in,
	input  wire logic        por_in,
	input  wire logic        lvd_stage1_in,
	input  wire logic        lvd_stage2_in,
	input  wire logic        osc_ok_in,
	input  wire logic        flash_init_done_in,
	input  wire logic [31:0] prot_word_in,
	input  wire logic        prot_word_valid_in,
	input  wire logic        programming_entry_pin_in,
	input  wire logic        irq_enable_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [31:0]      rdata_out,
	output logic             chip_reset_n_out,
	output logic             reset_status_out,
	output logic [31:0]      fetch_addr_out,
	output logic             lvd_irq_out,
	output logic             debug_allow_out,
	output logic             isp_allow_out,
	output logic             isp_limited_out,
	output logic             isp_full_erase_only_out,
	output logic             sector0_lock_out,
	output logic             isp_entry_out
);
	logic [1:0]  pin_sync;
	logic [1:0]  wdt_sync;
	logic [1:0]  por_sync;
	logic [1:0]  s1_sync;
	logic [1:0]  s2_sync;
	logic [1:0]  osc_sync;
	logic [1:0]  ent_sync;
	logic        s1_level;
	logic        s2_level;
	logic        reset_req;
	logic [15:0] wake_cnt;
	rbcp_state_e state;
	rbcp_level_e level;
	logic        stage1_irq_en;
	logic [3:0]  source_flags;
	logic        in_reset;

	// Pin-side inputs cross in through two flops; only the second stage is read.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			// The pin idles high; resetting its flops low would log a false pin reset.
			pin_sync <= 2'h3;
			wdt_sync <= 2'h0;
			por_sync <= 2'h3;
			s1_sync  <= 2'h0;
			s2_sync  <= 2'h0;
			osc_sync <= 2'h0;
			ent_sync <= 2'h0;
		end else begin
			pin_sync <= {pin_sync[0], reset_pin_n_in};
			wdt_sync <= {wdt_sync[0], watchdog_in};
			por_sync <= {por_sync[0], por_in};
			s1_sync  <= {s1_sync[0], lvd_stage1_in};
			s2_sync  <= {s2_sync[0], lvd_stage2_in};
			osc_sync <= {osc_sync[0], osc_ok_in};
			ent_sync <= {ent_sync[0], programming_entry_pin_in};
		end
	end

	// Stage-one threshold filter.
	rbcp_filter #(.COUNT(`RBCP_HYST_CYC)) u_filt_s1 (
		.core_clk_in (core_clk_in),
		.nrst_in     (nrst_in),
		.raw_in      (s1_sync[1]),
		.level_out   (s1_level)
	);

	// Stage-two threshold filter.
	rbcp_filter #(.COUNT(`RBCP_HYST_CYC)) u_filt_s2 (
		.core_clk_in (core_clk_in),
		.nrst_in     (nrst_in),
		.raw_in      (s2_sync[1]),
		.level_out   (s2_level)
	);

	// One combined request; the detector reset persists while power-on also asserts.
	assign reset_req = !pin_sync[1] | wdt_sync[1] | por_sync[1] | s2_level;

	// Wake-up sequencer: any request restarts the count from zero.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state    <= RBCP_ST_HOLD;
			wake_cnt <= 16'h0000;
		end else if (reset_req) begin
			state    <= RBCP_ST_HOLD;
			wake_cnt <= 16'h0000;
		end else begin
			unique case (state)
				RBCP_ST_HOLD: begin
					if (osc_sync[1]) begin
						state <= RBCP_ST_WAIT;
					end
				end
				RBCP_ST_WAIT: begin
					if (!osc_sync[1]) begin
						state    <= RBCP_ST_HOLD;
						wake_cnt <= 16'h0000;
					end else if (wake_cnt < 16'(WAKE_CYC)) begin
						wake_cnt <= wake_cnt + 16'h0001;
					end else if (flash_init_done_in) begin
						state <= RBCP_ST_RUN;
					end
				end
				RBCP_ST_RUN: begin
					state <= RBCP_ST_RUN;
				end
			endcase
		end
	end

	assign in_reset = (state != RBCP_ST_RUN);

	// Reset outputs and boot address; downstream registers reset while chip reset is low.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			chip_reset_n_out <= 1'b0;
			reset_status_out <= 1'b0;
			fetch_addr_out   <= `RBCP_BOOT_ADDR;
		end else begin
			chip_reset_n_out <= !in_reset;
			reset_status_out <= !in_reset && !reset_req;
			if (in_reset) begin
				fetch_addr_out <= `RBCP_BOOT_ADDR;
			end
		end
	end

	// Sticky record of what caused the last reset; a new cause wins over a software clear.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			source_flags <= 4'h4;
		end else begin
			for (int i = 0; i < 4; i++) begin
				logic hit;
				hit = (i == `RBCP_SRC_PIN) ? !pin_sync[1] :
				      (i == `RBCP_SRC_WDT) ? wdt_sync[1]  :
				      (i == `RBCP_SRC_POR) ? por_sync[1]  : s2_level;
				if (hit) begin
					source_flags[i] <= 1'b1;
				end else if (wr_in && addr_in == `RBCP_REG_SOURCE && wdata_in[i]) begin
					source_flags[i] <= 1'b0;
				end
			end
		end
	end

	// Software interrupt enable for stage one.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stage1_irq_en <= 1'b0;
		end else if (wr_in && addr_in == `RBCP_REG_CTRL) begin
			stage1_irq_en <= wdata_in[0];
		end
	end

	// Stage-one request goes out only when enabled; the level is still readable.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lvd_irq_out <= 1'b0;
		end else begin
			lvd_irq_out <= s1_level && irq_enable_in && stage1_irq_en;
		end
	end

	// Protection level is captured from the flash word while reset holds, then frozen.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			level <= RBCP_PROT_NONE;
		end else if (in_reset && prot_word_valid_in) begin
			unique case (prot_word_in)
				`RBCP_PAT_LEVEL1: level <= RBCP_PROT_ONE;
				`RBCP_PAT_LEVEL2: level <= RBCP_PROT_TWO;
				`RBCP_PAT_LEVEL3: level <= RBCP_PROT_THREE;
				default:          level <= RBCP_PROT_NONE;
			endcase
		end
	end

	// Access gates; application programming has no gate here at all.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			debug_allow_out         <= 1'b0;
			isp_allow_out           <= 1'b0;
			isp_limited_out         <= 1'b0;
			isp_full_erase_only_out <= 1'b0;
			sector0_lock_out        <= 1'b0;
			isp_entry_out           <= 1'b0;
		end else begin
			debug_allow_out         <= (level == RBCP_PROT_NONE);
			isp_allow_out           <= (level != RBCP_PROT_THREE);
			isp_limited_out         <= (level == RBCP_PROT_ONE);
			sector0_lock_out        <= (level == RBCP_PROT_ONE);
			isp_full_erase_only_out <= (level == RBCP_PROT_TWO);
			isp_entry_out           <= ent_sync[1] && (level != RBCP_PROT_THREE);
		end
	end

	// Read port; unmapped addresses read zero.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 32'h00000000;
		end else if (rd_in) begin
			unique case (addr_in)
				`RBCP_REG_STATUS: rdata_out <= {28'h0000000, s2_level, s1_level, state};
				`RBCP_REG_CTRL:   rdata_out <= {31'h00000000, stage1_irq_en};
				`RBCP_REG_PROT:   rdata_out <= {30'h00000000, level};
				`RBCP_REG_SOURCE: rdata_out <= {28'h0000000, source_flags};
				default:          rdata_out <= 32'h00000000;
			endcase
		end else begin
			rdata_out <= 32'h00000000;
		end
	end

	// Checks.
	chk_req_holds_reset: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reset_req |=> ##1 !chip_reset_n_out)
		else $error("chip reset released while a source requests it");
	chk_status_low: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!chip_reset_n_out |-> !reset_status_out)
		else $error("status high during reset");
	chk_release_wait: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$rose(chip_reset_n_out) |-> $past(flash_init_done_in))
		else $error("release without flash ready");
	chk_boot_addr: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$rose(chip_reset_n_out) |-> fetch_addr_out == `RBCP_BOOT_ADDR)
		else $error("boot address not zero");
	chk_irq_gate: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		lvd_irq_out |-> $past(s1_level) && $past(irq_enable_in))
		else $error("interrupt without cause or enable");
	chk_stage2_reset: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		s2_level |-> ##2 !chip_reset_n_out)
		else $error("second stage did not reset");
	chk_lvl3_block: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		level == RBCP_PROT_THREE |=> !isp_allow_out && !isp_entry_out && !debug_allow_out)
		else $error("level three leaks access");
	chk_lvl1_sector: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		level == RBCP_PROT_ONE |=> sector0_lock_out && isp_limited_out && !debug_allow_out)
		else $error("level one gates wrong");
	chk_lvl2_erase: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		level == RBCP_PROT_TWO |=> isp_full_erase_only_out && !debug_allow_out)
		else $error("level two gates wrong");
	cov_release: cover property (@(posedge core_clk_in) $rose(chip_reset_n_out));
	cov_irq: cover property (@(posedge core_clk_in) $rose(lvd_irq_out));
	cov_lvl3: cover property (@(posedge core_clk_in) level == RBCP_PROT_THREE);
endmodule

/* test/rbcp_partner.sv */
// Behavioural oscillator and flash controller facing the reset block.
module rbcp_partner (
	input  wire logic core_clk_in,
	input  wire logic nrst_in,
	input  wire logic chip_reset_n_in,
	input  wire logic slow_in,
	output logic      osc_ok_out,
	output logic      flash_init_done_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt;
	logic [5:0] limit;
	// The slow setting makes flash the last condition, so release must really wait for it.
	assign limit = slow_in ? 6'h28 : 6'h03;
	// Flash init restarts with every chip reset and is done only after the count runs out.
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt <= 6'h00;
			osc_ok_out <= 1'b0;
			flash_init_done_out <= 1'b0;
		end else begin
			osc_ok_out <= 1'b1;
			cnt <= chip_reset_n_in ? 6'h00 : (cnt == limit) ? cnt : cnt + 6'h01;
			flash_init_done_out <= chip_reset_n_in | (cnt == limit);
		end
	end
endmodule

/* test/tb_rbcp_top.sv */
// Self-checking testbench for the reset, low-voltage and protection block.
module tb_rbcp_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rbcp_pkg::*;
	logic clk = 0, nrst = 0, pin_n = 1, wdt = 0, por = 0, lv1 = 0, lv2 = 0, osc, fdone;
	logic [31:0] pword = 32'h0, wdata = 32'h0, rdata, faddr, d;
	logic pvalid = 0, entry = 0, irqen = 0, wr = 0, rd = 0, slow = 0;
	logic [3:0] addr = 4'h0;
	logic chip_n, status_o, irq, dbg, in_system_programming, lim, fe, s0, ient;
	int n_mismatch = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	rbcp_top #(.WAKE_CYC(4)) i_dut (.core_clk_in(clk), .nrst_in(nrst), .reset_pin_n_in(pin_n),
		.watchdog_in(wdt), .por_in(por), .lvd_stage1_in(lv1), .lvd_stage2_in(lv2),
		.osc_ok_in(osc), .flash_init_done_in(fdone), .prot_word_in(pword),
		.prot_word_valid_in(pvalid), .programming_entry_pin_in(entry), .irq_enable_in(irqen),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.chip_reset_n_out(chip_n), .reset_status_out(status_o), .fetch_addr_out(faddr),
		.lvd_irq_out(irq), .debug_allow_out(dbg), .isp_allow_out(in_system_programming), .isp_limited_out(lim),
		.isp_full_erase_only_out(fe), .sector0_lock_out(s0), .isp_entry_out(ient));
	rbcp_partner i_far (.core_clk_in(clk), .nrst_in(nrst), .chip_reset_n_in(chip_n),
		.slow_in(slow), .osc_ok_out(osc), .flash_init_done_out(fdone));
	// Every comparison is counted; a failed one is reported at once.
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic report_and_stop();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken just there.
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Bounded wait for release; a hang is cut short into the closing report.
	task automatic wait_run();
		int i;
		for (i = 0; i < 400 && chip_n !== 1'b1; i++) @(posedge clk);
		#1 chk(chip_n === 1'b1, "chip reset never released");
		if (chip_n !== 1'b1) report_and_stop();
		chk(status_o === 1'b1 && faddr === `RBCP_BOOT_ADDR, "bad state after release");
	endtask
	// Drives one reset source, checks the chip is held, then checks and clears its sticky bit.
	task automatic src_reset(input int s);
		@(posedge clk);
		case (s)
			0: pin_n <= 1'b0;
			1: wdt <= 1'b1;
			2: por <= 1'b1;
			default: lv2 <= 1'b1;
		endcase
		cyc(24);
		#1 chk(chip_n === 1'b0 && status_o === 1'b0, "source did not hold reset");
		@(posedge clk);
		{pin_n, wdt, por, lv2} <= 4'h8;
		wait_run();
		rd_reg(`RBCP_REG_SOURCE, d);
		chk(d[3:0] === (4'h1 << s), "wrong reset cause");
		wr_reg(`RBCP_REG_SOURCE, 32'hf);
		rd_reg(`RBCP_REG_SOURCE, d);
		chk(d === 32'h0, "cause not cleared");
		$display("test source %0d done", s);
	endtask
	// Level is latched from the flash word while in reset; one level-specific flag is checked, two for level one.
	task automatic prot(input logic [31:0] p, input logic [1:0] lv, input logic [2:0] e);
		pword <= p;
		pvalid <= 1'b1;
		entry <= 1'b1;
		src_reset(0);
		pvalid <= 1'b0;
		rd_reg(`RBCP_REG_PROT, d);
		chk(d === {30'h0, lv}, "protection level wrong");
		chk({dbg, in_system_programming} === e[2:1], "debug or programming gate wrong");
		case (lv)
			2'h1: chk(s0 === e[0] && lim === 1'b1, "sector 0 not locked");
			2'h2: chk(fe === e[0], "not limited to full erase");
			default: chk(ient === e[0], "pin entry handling wrong");
		endcase
		entry <= 1'b0;
		$display("test level %0d done", lv);
	endtask
	// Stage one raises the request only when enabled; the level stays visible either way.
	task automatic low_voltage();
		wr_reg(`RBCP_REG_CTRL, 32'h1);
		irqen <= 1'b1;
		lv1 <= 1'b1;
		cyc(8);
		lv1 <= 1'b0;
		cyc(24);
		rd_reg(`RBCP_REG_STATUS, d);
		chk(d[2] === 1'b0 && irq === 1'b0, "short dip passed the filter");
		lv1 <= 1'b1;
		cyc(24);
		#1 chk(irq === 1'b1, "interrupt not raised");
		irqen <= 1'b0;
		cyc(3);
		rd_reg(`RBCP_REG_STATUS, d);
		chk(irq === 1'b0 && d[2] === 1'b1 && chip_n === 1'b1, "masked level wrong");
		irqen <= 1'b1;
		wr_reg(`RBCP_REG_CTRL, 32'h0);
		cyc(3);
		#1 chk(irq === 1'b0, "control bit did not mask");
		lv1 <= 1'b0;
		cyc(24);
		rd_reg(`RBCP_REG_STATUS, d);
		chk(d === 32'h2, "status not back to running");
		$display("test low voltage done");
	endtask
	initial begin
		cyc(3);
		nrst <= 1'b1;
		slow <= 1'b1;
		#1 chk(chip_n === 1'b0 && status_o === 1'b0, "not in reset at start");
		wait_run();
		rd_reg(`RBCP_REG_SOURCE, d);
		chk(d === 32'h4 && dbg === 1'b1, "reset values wrong");
		wr_reg(`RBCP_REG_SOURCE, 32'hf);
		rd_reg(4'hf, d);
		chk(d === 32'h0, "unmapped read not zero");
		slow <= 1'b0;
		for (int s = 0; s < 4; s++) src_reset(s);
		low_voltage();
		prot(`RBCP_PAT_LEVEL1, 2'h1, 3'b011);
		prot(`RBCP_PAT_LEVEL2, 2'h2, 3'b011);
		prot(`RBCP_PAT_LEVEL3, 2'h3, 3'b000);
		prot(32'h0, 2'h0, 3'b111);
		report_and_stop();
	end
endmodule
